// ---- common/lab_regs.vh ----
// register map, field layout and sizes of the logic array block control.
// assumes a 32-bit avalon-mm slave with byte addresses, word aligned.
//
// Behaviour
// (R1) at most two block clocks, two enables
// (R2) each clock paired with its own enable
// (R3) both edges of one clock use both clocks
// (R4) low enable stops its block clock entirely
// (R5) no more than ten control signals at once
// (R6) two async clears and one async load
// (R7) async load with data high acts as preset
// (R8) block controls usable in every cell mode
// (R9) add/subtract honoured only in arithmetic mode
// (R10) normal mode: four local inputs feed lut
// (R11) lut input selects carry-in or fourth input
// (R12) normal mode async load data from fourth input
// (R13) lut chain passes output to next cell
// (R14) packed use: register and lut independent
// (R15) carry-in only at end of adder chain
// (R16) each output reaches up to thirty cells
// (R17) multiplier results feed adder or accumulator
// (R18) multiplier input registers chain as shift register
// (R19) sync clear/load act only while enabled
`ifndef LAB_REGS_VH
`define LAB_REGS_VH

`define LAB_NCELL        4
`define LAB_MAXCTRL      4'ha

// register byte offsets
`define LAB_OFF_CLKCFG   8'h00
`define LAB_OFF_MACCFG   8'h04
`define LAB_OFF_STATUS   8'h08
`define LAB_OFF_CELLOUT  8'h0c
`define LAB_OFF_MACOUT   8'h10
`define LAB_OFF_CELL0    8'h20

// clock configuration fields
`define LAB_CK_SRC1      0
`define LAB_CK_FALL1     1
`define LAB_CK_SRC2      2
`define LAB_CK_FALL2     3

// cell configuration fields
`define LAB_CF_LUT_HI    15
`define LAB_CF_ARITH     16
`define LAB_CF_CLKSEL    17
`define LAB_CF_CARRY     18
`define LAB_CF_CHAIN     19
`define LAB_CF_PACKED    20
`define LAB_CF_ACLR_LO   21
`define LAB_CF_ACLR_HI   22
`define LAB_CF_ALOAD     23
`define LAB_CF_PRESET    24
`define LAB_CF_SYNC      25

// multiplier configuration fields and modes
`define LAB_MC_MODE_LO   0
`define LAB_MC_MODE_HI   1
`define LAB_MC_SHIFT     2
`define LAB_MC_ACCCLR    3
`define LAB_MAC_PROD     2'h0
`define LAB_MAC_ADD      2'h1
`define LAB_MAC_SUB      2'h2
`define LAB_MAC_ACC      2'h3

`define LAB_ACLR_NONE    2'h0
`define LAB_ACLR_ZERO    2'h1
`define LAB_ACLR_ONE     2'h2

`define LAB_CLKCFG_RST   4'h0
`define LAB_CELLCFG_RST  32'h00000000
`define LAB_MACCFG_RST   4'h0

`endif

// ---- design/lab_ctrl.v ----
// logic array block: control distribution, four cells and a small multiplier block.
// assumes all pin inputs synchronous to clk_sys; block clocks are sampled
// edges of the two clock source inputs.
`timescale 1ns/1ps
`include "lab_regs.vh"

module lab_ctrl (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [1:0]  clkSrc,
  input  wire [1:0]  clkEna,
  input  wire [1:0]  aclr,
  input  wire        aload,
  input  wire        sclr,
  input  wire        sload,
  input  wire        addnsub,
  input  wire [15:0] cellData,
  input  wire [3:0]  cellPackIn,
  output reg  [3:0]  cellComb,
  output reg  [3:0]  cellReg,
  output reg         carryOut,
  input  wire        macValid,
  input  wire [7:0]  macA0,
  input  wire [7:0]  macB0,
  input  wire [7:0]  macA1,
  input  wire [7:0]  macB1,
  output reg  [19:0] macResult
);

  function edgeEvt;
    input srcNow;
    input srcPrev;
    input fall;
    begin
      edgeEvt = fall ? (~srcNow & srcPrev) : (srcNow & ~srcPrev);
    end
  endfunction

  reg  [3:0]  clkCfg_reg;
  reg  [3:0]  macCfg_reg;
  reg  [31:0] cellCfg_reg [0:`LAB_NCELL-1];
  reg  [1:0]  srcPrev_reg;
  reg         ack_reg;
  wire [3:0]  combW;
  wire [4:0]  carryW;
  wire [3:0]  arithW;
  wire [3:0]  clkUseW;
  wire        src1;
  wire        src2;
  wire        tick1;
  wire        tick2;
  wire        bothEdges;
  reg  [3:0]  ctrlCount;

  // block clock one and two: chosen source and edge, gated by own enable
  assign src1 = clkSrc[clkCfg_reg[`LAB_CK_SRC1]];
  assign src2 = clkSrc[clkCfg_reg[`LAB_CK_SRC2]];
  assign tick1 = edgeEvt(src1, srcPrev_reg[clkCfg_reg[`LAB_CK_SRC1]],
                         clkCfg_reg[`LAB_CK_FALL1]) & clkEna[0]; // R1 R2 R4
  assign tick2 = edgeEvt(src2, srcPrev_reg[clkCfg_reg[`LAB_CK_SRC2]],
                         clkCfg_reg[`LAB_CK_FALL2]) & clkEna[1]; // R1 R2 R4
  // one source on both edges occupies both block clocks
  assign bothEdges = (clkCfg_reg[`LAB_CK_SRC1] == clkCfg_reg[`LAB_CK_SRC2]) &
                     (clkCfg_reg[`LAB_CK_FALL1] != clkCfg_reg[`LAB_CK_FALL2]) &
                     (|clkUseW) & (|(~clkUseW)); // R3

  always @(posedge clk_sys) begin
    if (!rstn) begin
      srcPrev_reg <= 2'h0;
    end else begin
      srcPrev_reg <= clkSrc;
    end
  end

  // carry into the first cell: subtract needs an initial one
  assign carryW[0] = arithW[0] & addnsub; // R9

  genvar i;
  generate
    for (i = 0; i < `LAB_NCELL; i = i + 1) begin : gCell
      wire [31:0] cfg;
      wire [3:0]  d;
      wire        prevArith;
      wire        chainIn;
      wire        in0;
      wire        in3;
      wire [3:0]  lutIdx;
      wire        lutOut;
      wire        bEff;
      wire        sum;
      wire        tick;
      wire        aclrHit;
      wire        aloadVal;
      wire        regD;
      wire [1:0]  aclrSel;

      assign cfg = cellCfg_reg[i];
      assign d = cellData[4*i+3:4*i]; // R10
      assign arithW[i] = cfg[`LAB_CF_ARITH];
      assign clkUseW[i] = cfg[`LAB_CF_CLKSEL];
      if (i == 0) begin : gFirst
        assign prevArith = 1'b0;
        assign chainIn = 1'b0;
      end else begin : gNext
        assign prevArith = arithW[i-1];
        assign chainIn = combW[i-1];
      end
      assign in0 = cfg[`LAB_CF_CHAIN] ? chainIn : d[0]; // R13
      // carry-in replaces the fourth input only behind an adder chain
      assign in3 = (cfg[`LAB_CF_CARRY] & prevArith) ? carryW[i] : d[3]; // R11 R15
      assign lutIdx = {in3, d[2], d[1], in0}; // R10
      assign lutOut = cfg[lutIdx];
      assign bEff = d[1] ^ (cfg[`LAB_CF_ARITH] & addnsub); // R9
      assign sum = in0 ^ bEff ^ carryW[i];
      assign carryW[i+1] = cfg[`LAB_CF_ARITH] &
                           ((in0 & bEff) | (carryW[i] & (in0 ^ bEff)));
      assign combW[i] = cfg[`LAB_CF_ARITH] ? sum : lutOut;
      // packed, in normal mode only: register fed from its own input, lut output stays free
      assign regD = (cfg[`LAB_CF_PACKED] & ~cfg[`LAB_CF_ARITH]) ?
                    cellPackIn[i] : combW[i]; // R14
      assign tick = cfg[`LAB_CF_CLKSEL] ? tick2 : tick1; // R2
      assign aclrSel = cfg[`LAB_CF_ACLR_HI:`LAB_CF_ACLR_LO];
      assign aclrHit = ((aclrSel == `LAB_ACLR_ZERO) & aclr[0]) |
                       ((aclrSel == `LAB_ACLR_ONE) & aclr[1]); // R6
      assign aloadVal = cfg[`LAB_CF_PRESET] | d[3]; // R7 R12

      // clears and loads apply in every mode
      always @(posedge clk_sys) begin
        if (!rstn) begin
          cellReg[i] <= 1'b0;
        end else if (aclrHit) begin
          cellReg[i] <= 1'b0; // R6 R8
        end else if (cfg[`LAB_CF_ALOAD] & aload) begin
          cellReg[i] <= aloadVal; // R6 R7 R8
        end else if (tick) begin
          if (cfg[`LAB_CF_SYNC] & sclr) begin
            cellReg[i] <= 1'b0; // R8 R19
          end else if (cfg[`LAB_CF_SYNC] & sload) begin
            cellReg[i] <= d[3]; // R8 R19
          end else begin
            cellReg[i] <= regD; // R4
          end
        end
      end

      always @(posedge clk_sys) begin
        if (!rstn) begin
          cellComb[i] <= 1'b0;
        end else begin
          cellComb[i] <= combW[i]; // R16
        end
      end
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (!rstn) begin
      carryOut <= 1'b0;
    end else begin
      carryOut <= carryW[`LAB_NCELL];
    end
  end

  // distinct control signals in use by the current configuration
  always @* begin
    ctrlCount = 4'h2; // R5
    if (|clkUseW) begin
      ctrlCount = ctrlCount + 4'h2;
    end
    if (|(arithW)) begin
      ctrlCount = ctrlCount + 4'h1;
    end
    if (cellCfg_reg[0][`LAB_CF_ALOAD] | cellCfg_reg[1][`LAB_CF_ALOAD] |
        cellCfg_reg[2][`LAB_CF_ALOAD] | cellCfg_reg[3][`LAB_CF_ALOAD]) begin
      ctrlCount = ctrlCount + 4'h1;
    end
    if (cellCfg_reg[0][`LAB_CF_SYNC] | cellCfg_reg[1][`LAB_CF_SYNC] |
        cellCfg_reg[2][`LAB_CF_SYNC] | cellCfg_reg[3][`LAB_CF_SYNC]) begin
      ctrlCount = ctrlCount + 4'h2;
    end
    if (ctrlCount > `LAB_MAXCTRL) begin
      ctrlCount = `LAB_MAXCTRL; // R5
    end
  end

  // multiplier block
  reg  [7:0]  mA0_reg;
  reg  [7:0]  mB0_reg;
  reg  [7:0]  mA1_reg;
  reg  [7:0]  mB1_reg;
  wire [15:0] prod0;
  wire [15:0] prod1;
  reg  [19:0] macNext;

  assign prod0 = mA0_reg * mB0_reg;
  assign prod1 = mA1_reg * mB1_reg;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      mA0_reg <= 8'h00;
      mB0_reg <= 8'h00;
      mA1_reg <= 8'h00;
      mB1_reg <= 8'h00;
    end else if (macValid) begin
      mA0_reg <= macA0;
      mB0_reg <= macB0;
      // shift mode: second input register follows the first
      mA1_reg <= macCfg_reg[`LAB_MC_SHIFT] ? mA0_reg : macA1; // R18
      mB1_reg <= macCfg_reg[`LAB_MC_SHIFT] ? mB0_reg : macB1; // R18
    end
  end

  always @* begin
    case (macCfg_reg[`LAB_MC_MODE_HI:`LAB_MC_MODE_LO])
      `LAB_MAC_ADD: macNext = {4'h0, prod0} + {4'h0, prod1}; // R17
      `LAB_MAC_SUB: macNext = {4'h0, prod0} - {4'h0, prod1}; // R17
      `LAB_MAC_ACC: macNext = macResult + {4'h0, prod0}; // R17
      default:      macNext = {4'h0, prod0};
    endcase
  end

  wire isWrite;
  assign isWrite = avs_write & ack_reg;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      macResult <= 20'h00000;
    end else if (isWrite & (avs_address == `LAB_OFF_MACCFG) &
                 avs_writedata[`LAB_MC_ACCCLR]) begin
      macResult <= 20'h00000;
    end else if (macValid) begin
      macResult <= macNext;
    end
  end

  // avalon slave: one wait state, write acts at the edge waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  integer k;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      clkCfg_reg <= `LAB_CLKCFG_RST;
      macCfg_reg <= `LAB_MACCFG_RST;
      for (k = 0; k < `LAB_NCELL; k = k + 1) begin
        cellCfg_reg[k] <= `LAB_CELLCFG_RST;
      end
    end else if (isWrite) begin
      case (avs_address)
        `LAB_OFF_CLKCFG: clkCfg_reg <= avs_writedata[3:0];
        `LAB_OFF_MACCFG: macCfg_reg <= {1'b0, avs_writedata[2:0]};
        default: begin
          for (k = 0; k < `LAB_NCELL; k = k + 1) begin
            if (avs_address == `LAB_OFF_CELL0 + 8'h04 * k[7:0]) begin
              cellCfg_reg[k] <= avs_writedata;
            end
          end
        end
      endcase
    end
  end

  reg [31:0] rdMux;
  integer    j;
  always @* begin
    rdMux = 32'h00000000;
    case (avs_address)
      `LAB_OFF_CLKCFG:  rdMux = {28'h0000000, clkCfg_reg};
      `LAB_OFF_MACCFG:  rdMux = {28'h0000000, macCfg_reg};
      `LAB_OFF_STATUS:  rdMux = {24'h000000, ctrlCount, 3'h0, bothEdges};
      `LAB_OFF_CELLOUT: rdMux = {23'h000000, carryOut, cellComb, cellReg};
      `LAB_OFF_MACOUT:  rdMux = {12'h000, macResult};
      default: begin
        for (j = 0; j < `LAB_NCELL; j = j + 1) begin
          if (avs_address == `LAB_OFF_CELL0 + 8'h04 * j[7:0]) begin
            rdMux = cellCfg_reg[j];
          end
        end
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= rdMux;
    end
  end

endmodule // lab_ctrl

// ---- dv/lab_ctrl_props.sv ----
// checker: port-level timing of the logic array block control.
// assumes one clk_sys domain; bound to every lab_ctrl instance.
`timescale 1ns/1ps
`include "lab_regs.vh"
module lab_ctrl_props (
  input wire        clk_sys,
  input wire        rstn,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  clkEna,
  input wire [1:0]  aclr,
  input wire        aload,
  input wire        macValid,
  input wire [3:0]  cellComb,
  input wire [3:0]  cellReg,
  input wire        carryOut,
  input wire [19:0] macResult
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_pend;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_quiet;
    clkEna == 2'h0 && aclr == 2'h0 && !aload;
  endsequence
  sequence s_rd_done;
    avs_read && !avs_waitrequest;
  endsequence
  a_one_wait_state: assert property (s_pend |=> !avs_waitrequest)
    else $error("waitrequest held beyond one wait state");
  a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_off_holds_reg: assert property (s_quiet [*3] |-> $stable(cellReg))
    else $error("cell register moved while both enables low");
  a_reset_clears_outs: assert property ($rose(rstn) |->
    cellReg == 4'h0 && cellComb == 4'h0 && macResult == 20'h0 && !carryOut)
    else $error("outputs not cleared by reset");
  a_rdata_stands: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_mac_holds: assert property (!macValid && !avs_write |=> $stable(macResult))
    else $error("multiplier result moved without a pulse");
  a_ctrl_limit: assert property (s_rd_done ##0 (avs_address == `LAB_OFF_STATUS) |->
    avs_readdata[7:4] <= `LAB_MAXCTRL)
    else $error("control signal count above limit");
  a_unmapped_zero: assert property (s_rd_done ##0 (avs_address == 8'h14) |->
    avs_readdata == 32'h0)
    else $error("unmapped address read nonzero");
endmodule // lab_ctrl_props

bind lab_ctrl lab_ctrl_props u_props (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .clkEna, .aclr, .aload, .macValid, .cellComb, .cellReg,
  .carryOut, .macResult);

// ---- dv/lab_fabric_model.sv ----
// partner: routing fabric driving the two clock source lines.
// assumes stepReq changes right after a clk_sys rising edge.
`timescale 1ns/1ps
module lab_fabric_model (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire [1:0] stepReq,
  output reg  [1:0] clkSrc
);
  // lines stand still unless a step is asked for
  always @(posedge clk_sys) begin
    if (!rstn) begin
      clkSrc <= 2'h0;
    end else begin
      clkSrc <= clkSrc ^ stepReq;
    end
  end
endmodule // lab_fabric_model

// ---- dv/tb_logic_array_block_control.sv ----
// testbench: register bus, cell control and multiplier scenarios.
// assumes lab_ctrl with one wait state per bus request.
`timescale 1ns/1ps
`include "lab_regs.vh"
module tb_logic_array_block_control;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, rd;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, carryOut;
  logic [1:0]  stepReq = 2'h0, clkEna = 2'h0, aclr = 2'h0;
  wire  [1:0]  clkSrc;
  logic        aload = 1'b0, sclr = 1'b0, sload = 1'b0, addnsub = 1'b0, macValid = 1'b0;
  logic [15:0] cellData = 16'h0;
  logic [3:0]  cellPackIn = 4'h0;
  wire  [3:0]  cellComb, cellReg;
  logic [7:0]  macA0 = 8'h03, macB0 = 8'h05, macA1 = 8'h02, macB1 = 8'h04;
  wire  [19:0] macResult;
  logic [31:0] macExp [4] = '{32'hf, 32'h17, 32'h7, 32'h1e};
  int          failures = 0, samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  lab_fabric_model fabric (.clk_sys, .rstn, .stepReq, .clkSrc);
  lab_ctrl DUT (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .clkSrc, .clkEna, .aclr, .aload, .sclr, .sload,
    .addnsub, .cellData, .cellPackIn, .cellComb, .cellReg, .carryOut, .macValid, .macA0,
    .macB0, .macA1, .macB1, .macResult);

  task automatic final_report;
    $display("compared %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one rising then one falling step on the chosen source lines
  task automatic tick(input logic [1:0] s);
    repeat (2) begin
      stepReq <= s;
      @(posedge clk_sys);
      stepReq <= 2'h0;
      idle(4);
    end
  endtask

  initial begin
    idle(20);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdc("clkcfg", `LAB_OFF_CLKCFG, 32'h0);
    rdc("maccfg", `LAB_OFF_MACCFG, 32'h0);
    bus(1'b1, 8'h14, 32'hffffffff);
    rdc("unmapped", 8'h14, 32'h0);
    bus(1'b1, `LAB_OFF_CLKCFG, 32'h4);
    rdc("clkcfg", `LAB_OFF_CLKCFG, 32'h4);
    bus(1'b1, `LAB_OFF_CELL0, 32'h02008000);
    bus(1'b1, `LAB_OFF_CELL0 + 8'h04, 32'h0002ffff);
    bus(1'b1, `LAB_OFF_CELL0 + 8'h08, 32'h0020ffff);
    bus(1'b1, `LAB_OFF_CELL0 + 8'h0c, 32'h01c00000);
    cellData <= 16'h000f;
    clkEna <= 2'h2;
    tick(2'h1);
    chk("wrong pair", 32'(cellReg), 32'h0);
    chk("lut", 32'(cellComb), 32'h7);
    addnsub <= 1'b1;
    idle(4);
    chk("addsub", 32'(cellComb), 32'h7);
    tick(2'h2);
    chk("clock two", 32'(cellReg), 32'h2);
    clkEna <= 2'h1;
    tick(2'h1);
    chk("clock one", 32'(cellReg), 32'h7);
    aclr <= 2'h1;
    idle(3);
    aclr <= 2'h0;
    idle(3);
    chk("clear one", 32'(cellReg), 32'h3);
    aload <= 1'b1;
    idle(3);
    chk("preset", 32'(cellReg), 32'hb);
    aclr <= 2'h2;
    idle(3);
    chk("clear two", 32'(cellReg), 32'h3);
    aload <= 1'b0;
    aclr <= 2'h0;
    bus(1'b1, `LAB_OFF_CELL0 + 8'h0c, 32'h00800000);
    cellData <= 16'h800f;
    aload <= 1'b1;
    idle(3);
    chk("load high", 32'(cellReg), 32'hb);
    cellData <= 16'h000f;
    idle(3);
    chk("load low", 32'(cellReg), 32'h3);
    aload <= 1'b0;
    clkEna <= 2'h0;
    sclr <= 1'b1;
    tick(2'h3);
    chk("sclr off", 32'(cellReg), 32'h3);
    clkEna <= 2'h3;
    tick(2'h3);
    chk("sclr on", 32'(cellReg), 32'h6);
    sclr <= 1'b0;
    bus(1'b0, `LAB_OFF_STATUS, 32'h0);
    chk("one edge", 32'(rd[0]), 32'h0);
    bus(1'b1, `LAB_OFF_CLKCFG, 32'h8);
    bus(1'b0, `LAB_OFF_STATUS, 32'h0);
    chk("both edges", 32'(rd[0]), 32'h1);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `LAB_OFF_CELL0 + 8'(4 * c), 32'h00010000);
    end
    cellData <= 16'h1113;
    addnsub <= 1'b0;
    idle(3);
    rdc("add", `LAB_OFF_CELLOUT, 32'h106);
    addnsub <= 1'b1;
    idle(3);
    rdc("sub", `LAB_OFF_CELLOUT, 32'h1e6);
    addnsub <= 1'b0;
    bus(1'b1, `LAB_OFF_CELL0 + 8'h04, 32'h0004ff00);
    bus(1'b1, `LAB_OFF_CELL0 + 8'h08, 32'h0008aaaa);
    bus(1'b1, `LAB_OFF_CELL0 + 8'h0c, 32'h0004ff00);
    cellData <= 16'h0003;
    idle(3);
    rdc("chain", `LAB_OFF_CELLOUT, 32'h066);
    bus(1'b1, `LAB_OFF_CELL0 + 8'h0c, 32'h02100000);
    cellPackIn <= 4'h8;
    tick(2'h1);
    chk("packed", 32'(cellReg[3]), 32'h1);
    chk("packed lut", 32'(cellComb[3]), 32'h0);
    sload <= 1'b1;
    tick(2'h1);
    chk("sload", 32'(cellReg[3]), 32'h0);
    sload <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `LAB_OFF_MACCFG, m | 32'h8);
      repeat (2) begin
        macValid <= 1'b1;
        @(posedge clk_sys);
        macValid <= 1'b0;
        @(posedge clk_sys);
      end
      chk("mac", 32'(macResult), macExp[m]);
    end
    bus(1'b1, `LAB_OFF_MACCFG, 32'hd);
    repeat (2) begin
      macValid <= 1'b1;
      @(posedge clk_sys);
      macValid <= 1'b0;
      @(posedge clk_sys);
    end
    rdc("shift", `LAB_OFF_MACOUT, 32'h1e);
    final_report();
  end

  initial begin
    idle(5000);
    failures++;
    final_report();
  end
endmodule // tb_logic_array_block_control
